// ### hdl/adcsc_defs.vh
// Constants of the converter sequence control block
//
// Operation
// [R01] Averaging codes 000..011 average 1, 2, 4 or 8 samples; reset code 000.
// [R02] Software changes averaging only while the converter is stopped.
// [R03] Averaging completes for one channel before the next channel is taken.
// [R04] Averaging codes with top bit set select test modes with four polarities.
// [R05] A finished conversion writes both result bytes and sets done flag bit 1.
// [R06] Setting the done flag requests an interrupt when interrupts are enabled.
// [R07] Reading the low result byte clears the done flag.
// [R08] While the done flag is set, new results are dropped, bytes unchanged.
// [R09] Writing one to control bit 0 launches a conversion on selected channel.
// [R10] The start bit clears itself when the conversion finishes.
// [R11] Amplifier register bit 6 picks high supply (0) or core supply (1) reference.
// [R12] Amplifier register bit 5 picks high or core supply minus 0.4 V.
// [R13] Divider codes 0..7 divide the system clock by 2 up to 256.
// [R14] Channel codes route pin, amplifier, bandgap, temperature, supplies; 110/111 reserved.
// [R15] Amplifier register reads as zero; bit 7 enables, low two bits set gain.
// [R16] Conversion interrupt enable one allows the interrupt, zero suppresses it.
// [R17] Alignment zero right-aligns: high byte top nibble zero, low byte the rest.
// [R18] Software waits 20 us after enabling the converter before any start.
`ifndef ADCSC_DEFS_VH
`define ADCSC_DEFS_VH

// ****************************************
// Register addresses
// ****************************************
`define ADCSC_ADDR_CFG 8'hA9
`define ADCSC_ADDR_AMP 8'hB9
`define ADCSC_ADDR_RESL 8'hBA
`define ADCSC_ADDR_RESH 8'hBB
`define ADCSC_ADDR_CTRL 8'hCE
`define ADCSC_ADDR_ISTAT 8'hC0
`define ADCSC_ADDR_ICLR 8'hC1
`define ADCSC_ADDR_IEN 8'hC2

// ****************************************
// Reset values
// ****************************************
`define ADCSC_RST_BYTE 8'h00
`define ADCSC_RST_IRQ 2'h0

// ****************************************
// Control register fields
// ****************************************
`define ADCSC_CTRL_START 0
`define ADCSC_CTRL_DONE 1
`define ADCSC_CTRL_CH_HI 4
`define ADCSC_CTRL_CH_LO 2
`define ADCSC_CTRL_AVG_HI 7
`define ADCSC_CTRL_AVG_LO 5
`define ADCSC_AVG_TEST 2

// ****************************************
// Configuration register fields
// ****************************************
`define ADCSC_CFG_EN 7
`define ADCSC_CFG_IRQEN 6
`define ADCSC_CFG_ALIGN 5
`define ADCSC_CFG_TEMP 4
`define ADCSC_CFG_VDDS 3
`define ADCSC_CFG_DIV_HI 2
`define ADCSC_CFG_DIV_LO 0

// ****************************************
// Amplifier register fields
// ****************************************
`define ADCSC_AMP_EN 7
`define ADCSC_AMP_FSREF 6
`define ADCSC_AMP_VXREF 5
`define ADCSC_AMP_GND 2
`define ADCSC_AMP_GAIN_HI 1
`define ADCSC_AMP_GAIN_LO 0

// ****************************************
// Interrupt status bits
// ****************************************
`define ADCSC_IRQ_DONE 0
`define ADCSC_IRQ_DROP 1

// ****************************************
// Widths and counts
// ****************************************
`define ADCSC_RES_W 12
`define ADCSC_ACC_W 15
`define ADCSC_DIV_W 8
`define ADCSC_DIV_ALL 8'hFF
`define ADCSC_DIV_TOP 3'h7
`define ADCSC_NIB_ZERO 4'h0

`endif

// ### hdl/adcsc_clk_div.v
// Conversion clock divider of the converter sequence control block
`timescale 1ns/100ps
`default_nettype none
`include "adcsc_defs.vh"

module adcsc_clk_div (
  input wire mclk,
  input wire nrst,
  input wire run,
  input wire [2:0] divSel,
  output reg convClk_r,
  output wire divTick
);

  // ****************************************
  // Divide by two to the power of code plus one
  // ****************************************
  reg [`ADCSC_DIV_W-1:0] cnt_r;
  wire [`ADCSC_DIV_W-1:0] term;
  wire [`ADCSC_DIV_W-1:0] cnt_nxt;

  assign term = `ADCSC_DIV_ALL >> (`ADCSC_DIV_TOP - divSel); // [R13]
  assign divTick = run && (cnt_r == term);
  assign cnt_nxt = (!run || divTick) ? {`ADCSC_DIV_W{1'b0}} : cnt_r + 8'h01;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= {`ADCSC_DIV_W{1'b0}};
      convClk_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      convClk_r <= cnt_nxt[divSel]; // [R13]
    end
  end

endmodule // adcsc_clk_div
`default_nettype wire

// ### hdl/adcsc_avg_acc.v
// Sample accumulator for hardware averaging
`timescale 1ns/100ps
`default_nettype none
`include "adcsc_defs.vh"

module adcsc_avg_acc (
  input wire mclk,
  input wire nrst,
  input wire clr,
  input wire add,
  input wire [`ADCSC_RES_W-1:0] sample,
  input wire [1:0] depth,
  output wire lastSample,
  output reg [`ADCSC_RES_W-1:0] avgResult_r,
  output reg avgDone_r
);

  reg [`ADCSC_ACC_W-1:0] acc_r;
  reg [3:0] cnt_r;
  wire [`ADCSC_ACC_W-1:0] accSum;
  wire [`ADCSC_ACC_W-1:0] accAvg;
  wire [3:0] needCnt;

  // ****************************************
  // Sum 1, 2, 4 or 8 samples, shift down by depth
  // ****************************************
  assign needCnt = 4'h1 << depth; // [R01]
  assign lastSample = add && (cnt_r == needCnt - 4'h1);
  assign accSum = acc_r + {3'h0, sample};
  assign accAvg = accSum >> depth;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= {`ADCSC_ACC_W{1'b0}};
      cnt_r <= 4'h0;
      avgResult_r <= {`ADCSC_RES_W{1'b0}};
      avgDone_r <= 1'b0;
    end else begin
      avgDone_r <= lastSample;
      if (clr) begin
        acc_r <= {`ADCSC_ACC_W{1'b0}};
        cnt_r <= 4'h0;
      end else if (add) begin
        acc_r <= accSum;
        cnt_r <= cnt_r + 4'h1;
        if (lastSample) begin
          avgResult_r <= accAvg[`ADCSC_RES_W-1:0]; // [R01]
        end
      end
    end
  end

endmodule // adcsc_avg_acc
`default_nettype wire

// ### hdl/adcsc_top.v
// Converter sequence control: registers, conversion sequencing, results, interrupt
`timescale 1ns/100ps
`default_nettype none
`include "adcsc_defs.vh"

module adcsc_top (
  input wire mclk,
  input wire nrst,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata_r,
  output wire sampleReq,
  input wire sampleDone,
  input wire [`ADCSC_RES_W-1:0] sampleData,
  output wire convClk,
  output wire converterEnable,
  output wire [2:0] inputChannelSelect,
  output wire channelReserved,
  output wire testMode,
  output wire [1:0] testPolarity,
  output wire tempSensorEnable,
  output wire supplyDividerEnable,
  output wire amplifierEnable,
  output wire fullscaleReferenceSelect,
  output wire amplifierReferenceSelect,
  output wire amplifierInputGround,
  output wire [1:0] amplifierGain,
  output wire convBusy,
  output wire irq
);

  // ****************************************
  // Sequencer states
  // ****************************************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_REQ = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;
  localparam [1:0] ST_FIN = 2'h3;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] cfg_r;
  reg [7:0] amp_r;
  reg [2:0] avgDepth_r;
  reg [2:0] input_channel_select_r;
  reg convTrigger_r;
  reg convTrigger_nxt;
  reg doneFlag_r;
  reg doneFlag_nxt;
  reg [7:0] resLow_r;
  reg [7:0] resHigh_r;
  reg [1:0] irqStat_r;
  reg [1:0] irqStat_nxt;
  reg [1:0] irqEn_r;
  reg sampleReq_r;
  reg sampleReq_nxt;
  reg accClr;
  reg accAdd;
  reg [7:0] rdData;

  wire wrCfg;
  wire wrAmp;
  wire wrCtrl;
  wire wrIclr;
  wire wrIen;
  wire rdLow;
  wire divTick;
  wire lastSample;
  wire avgDone;
  wire [`ADCSC_RES_W-1:0] avgResult;
  wire [1:0] accDepth;
  wire resultLand;
  wire resultDrop;
  wire [7:0] fmtHigh;
  wire [7:0] fmtLow;

  // ****************************************
  // Address decode
  // ****************************************
  assign wrCfg = regWr && (regAddr == `ADCSC_ADDR_CFG);
  assign wrAmp = regWr && (regAddr == `ADCSC_ADDR_AMP);
  assign wrCtrl = regWr && (regAddr == `ADCSC_ADDR_CTRL);
  assign wrIclr = regWr && (regAddr == `ADCSC_ADDR_ICLR);
  assign wrIen = regWr && (regAddr == `ADCSC_ADDR_IEN);
  assign rdLow = regRd && (regAddr == `ADCSC_ADDR_RESL);

  // ****************************************
  // Software written settings
  // ****************************************
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= `ADCSC_RST_BYTE;
      amp_r <= `ADCSC_RST_BYTE;
      avgDepth_r <= 3'h0; // [R01]
      input_channel_select_r <= 3'h0;
      irqEn_r <= `ADCSC_RST_IRQ;
    end else begin
      if (wrCfg) begin
        cfg_r <= regWdata;
      end
      if (wrAmp) begin
        amp_r <= regWdata; // [R15]
      end
      if (wrCtrl) begin
        avgDepth_r <= regWdata[`ADCSC_CTRL_AVG_HI:`ADCSC_CTRL_AVG_LO];
        input_channel_select_r <= regWdata[`ADCSC_CTRL_CH_HI:`ADCSC_CTRL_CH_LO];
      end
      if (wrIen) begin
        irqEn_r <= regWdata[1:0];
      end
    end
  end

  // ****************************************
  // Outputs to the analog side
  // ****************************************
  assign converterEnable = cfg_r[`ADCSC_CFG_EN];
  assign tempSensorEnable = cfg_r[`ADCSC_CFG_TEMP];
  assign supplyDividerEnable = cfg_r[`ADCSC_CFG_VDDS];
  assign inputChannelSelect = input_channel_select_r; // [R14]
  assign channelReserved = input_channel_select_r[2] && input_channel_select_r[1]; // [R14]
  assign testMode = avgDepth_r[`ADCSC_AVG_TEST]; // [R04]
  assign testPolarity = avgDepth_r[1:0]; // [R04]
  assign amplifierEnable = amp_r[`ADCSC_AMP_EN]; // [R15]
  assign fullscaleReferenceSelect = amp_r[`ADCSC_AMP_FSREF]; // [R11]
  assign amplifierReferenceSelect = amp_r[`ADCSC_AMP_VXREF]; // [R12]
  assign amplifierInputGround = amp_r[`ADCSC_AMP_GND];
  assign amplifierGain = amp_r[`ADCSC_AMP_GAIN_HI:`ADCSC_AMP_GAIN_LO]; // [R15]
  assign sampleReq = sampleReq_r;
  assign convBusy = convTrigger_r;

  // ****************************************
  // Conversion clock
  // ****************************************
  adcsc_clk_div uDiv (
    .mclk(mclk),
    .nrst(nrst),
    .run(converterEnable),
    .divSel(cfg_r[`ADCSC_CFG_DIV_HI:`ADCSC_CFG_DIV_LO]),
    .convClk_r(convClk),
    .divTick(divTick)
  );

  // ****************************************
  // Averaging; test modes take one sample
  // ****************************************
  assign accDepth = testMode ? 2'h0 : avgDepth_r[1:0]; // [R04]

  adcsc_avg_acc uAvg (
    .mclk(mclk),
    .nrst(nrst),
    .clr(accClr),
    .add(accAdd),
    .sample(sampleData),
    .depth(accDepth),
    .lastSample(lastSample),
    .avgResult_r(avgResult),
    .avgDone_r(avgDone)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always @* begin
    state_nxt = state_r;
    sampleReq_nxt = sampleReq_r;
    accClr = 1'b0;
    accAdd = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (convTrigger_r) begin
          accClr = 1'b1; // [R09]
          state_nxt = ST_REQ;
        end
      end
      ST_REQ: begin
        if (divTick) begin
          sampleReq_nxt = 1'b1;
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (sampleDone) begin
          sampleReq_nxt = 1'b0;
          accAdd = 1'b1;
          // The one selected channel finishes its average before the sequence ends
          state_nxt = lastSample ? ST_FIN : ST_REQ; // [R03]
        end
      end
      ST_FIN: begin
        if (avgDone) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Result formatting
  // ****************************************
  assign fmtHigh = cfg_r[`ADCSC_CFG_ALIGN] ? avgResult[11:4] :
    {`ADCSC_NIB_ZERO, avgResult[11:8]}; // [R17]
  assign fmtLow = cfg_r[`ADCSC_CFG_ALIGN] ? {avgResult[3:0], `ADCSC_NIB_ZERO} :
    avgResult[7:0]; // [R17]

  assign resultLand = avgDone && !doneFlag_r; // [R05]
  assign resultDrop = avgDone && doneFlag_r; // [R08]

  // ****************************************
  // Start bit and done flag
  // ****************************************
  always @* begin
    convTrigger_nxt = convTrigger_r;
    if (wrCtrl && regWdata[`ADCSC_CTRL_START]) begin
      convTrigger_nxt = 1'b1; // [R09]
    end
    if (avgDone) begin
      convTrigger_nxt = 1'b0; // [R10]
    end
    // Set beats the clearing read in the same cycle
    doneFlag_nxt = resultLand || (doneFlag_r && !rdLow); // [R05] [R07]
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      sampleReq_r <= 1'b0;
      convTrigger_r <= 1'b0;
      doneFlag_r <= 1'b0;
      resLow_r <= `ADCSC_RST_BYTE;
      resHigh_r <= `ADCSC_RST_BYTE;
    end else begin
      state_r <= state_nxt;
      sampleReq_r <= sampleReq_nxt;
      convTrigger_r <= convTrigger_nxt;
      doneFlag_r <= doneFlag_nxt;
      if (resultLand) begin
        resLow_r <= fmtLow; // [R05]
        resHigh_r <= fmtHigh; // [R05]
      end
    end
  end

  // ****************************************
  // Interrupt status, clear and enable
  // ****************************************
  always @* begin
    irqStat_nxt = irqStat_r;
    if (wrIclr) begin
      irqStat_nxt = irqStat_r & ~regWdata[1:0];
    end
    if (resultLand && cfg_r[`ADCSC_CFG_IRQEN]) begin
      irqStat_nxt[`ADCSC_IRQ_DONE] = 1'b1; // [R06] [R16]
    end
    if (resultDrop) begin
      irqStat_nxt[`ADCSC_IRQ_DROP] = 1'b1;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irqStat_r <= `ADCSC_RST_IRQ;
    end else begin
      irqStat_r <= irqStat_nxt;
    end
  end

  assign irq = |(irqStat_r & irqEn_r); // [R06]

  // ****************************************
  // Read data, one cycle after the strobe
  // ****************************************
  always @* begin
    rdData = `ADCSC_RST_BYTE;
    case (regAddr)
      `ADCSC_ADDR_CFG: begin
        rdData = cfg_r;
      end
      `ADCSC_ADDR_CTRL: begin
        rdData = {avgDepth_r, input_channel_select_r, doneFlag_r, convTrigger_r}; // [R10]
      end
      `ADCSC_ADDR_RESL: begin
        rdData = resLow_r;
      end
      `ADCSC_ADDR_RESH: begin
        rdData = resHigh_r;
      end
      `ADCSC_ADDR_ISTAT: begin
        rdData = {6'h00, irqStat_r};
      end
      `ADCSC_ADDR_IEN: begin
        rdData = {6'h00, irqEn_r};
      end
      default: begin
        // Amplifier, clear and unmapped addresses read as zero
        rdData = `ADCSC_RST_BYTE; // [R15]
      end
    endcase
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      regRdata_r <= `ADCSC_RST_BYTE;
    end else if (regRd) begin
      regRdata_r <= rdData;
    end else begin
      regRdata_r <= `ADCSC_RST_BYTE;
    end
  end

endmodule // adcsc_top
`default_nettype wire

// ### tb/adcsc_asserts.sv
// Checker of the converter sequence control block
`timescale 1ns/100ps
`default_nettype none
module adcsc_asserts (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata_r,
  input wire logic sampleReq,
  input wire logic sampleDone,
  input wire logic convClk,
  input wire logic converterEnable,
  input wire logic [2:0] inputChannelSelect,
  input wire logic channelReserved,
  input wire logic testMode,
  input wire logic [1:0] testPolarity,
  input wire logic amplifierEnable,
  input wire logic fullscaleReferenceSelect,
  input wire logic amplifierReferenceSelect,
  input wire logic amplifierInputGround,
  input wire logic [1:0] amplifierGain,
  input wire logic convBusy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic ctlWr = regWr && regAddr == 8'hCE;
  property p_amprd; $past(regRd) && $past(regAddr) == 8'hB9 |-> regRdata_r == 8'h00; endproperty
  a_amprd: assert property (p_amprd) else $error("amp read not zero");
  property p_amp; regWr && regAddr == 8'hB9 |=> {amplifierEnable, fullscaleReferenceSelect,
    amplifierReferenceSelect} == $past(regWdata[7:5])
    && {amplifierInputGround, amplifierGain} == $past(regWdata[2:0]); endproperty
  a_amp: assert property (p_amp) else $error("amp fields wrong");
  property p_chres; channelReserved == (inputChannelSelect > 3'h5); endproperty
  a_chres: assert property (p_chres) else $error("reserved channel flag wrong");
  property p_input_channel_select; ctlWr |=> inputChannelSelect == $past(regWdata[4:2]); endproperty
  a_input_channel_select: assert property (p_input_channel_select) else $error("channel select wrong");
  property p_avg; ctlWr |=> {testMode, testPolarity} == $past(regWdata[7:5]); endproperty
  a_avg: assert property (p_avg) else $error("averaging field wrong");
  property p_start; ctlWr && regWdata[0] |=> convBusy; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_fin; sampleDone && sampleReq && (testMode || testPolarity == 2'h0)
    |-> ##2 !convBusy; endproperty
  a_fin: assert property (p_fin) else $error("start bit not cleared");
  property p_req; sampleReq |-> convBusy; endproperty
  a_req: assert property (p_req) else $error("sample request while idle");
  property p_clk; !converterEnable [*2] |=> $stable(convClk); endproperty
  a_clk: assert property (p_clk) else $error("divider runs while disabled");
endmodule // adcsc_asserts
bind adcsc_top adcsc_asserts u_chk (.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r),
  .sampleReq(sampleReq), .sampleDone(sampleDone), .convClk(convClk),
  .converterEnable(converterEnable), .inputChannelSelect(inputChannelSelect),
  .channelReserved(channelReserved), .testMode(testMode), .testPolarity(testPolarity),
  .amplifierEnable(amplifierEnable), .fullscaleReferenceSelect(fullscaleReferenceSelect),
  .amplifierReferenceSelect(amplifierReferenceSelect),
  .amplifierInputGround(amplifierInputGround), .amplifierGain(amplifierGain),
  .convBusy(convBusy));
`default_nettype wire

// ### tb/adc_sequence_control_tb_top.sv
// Self-checking testbench of the converter sequence control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin badCount++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module adc_sequence_control_tb_top;
  logic mclk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, sampleDone = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata_r;
  logic [11:0] sampleData = 12'h000;
  logic sampleReq, convClk, converterEnable, channelReserved, testMode, tempSensorEnable;
  logic supplyDividerEnable, amplifierEnable, fullscaleReferenceSelect, amplifierReferenceSelect;
  logic amplifierInputGround, convBusy, irq;
  logic [2:0] inputChannelSelect;
  logic [1:0] testPolarity, amplifierGain;
  wire [5:0] ampBits = {amplifierEnable, fullscaleReferenceSelect, amplifierReferenceSelect,
    amplifierInputGround, amplifierGain};
  wire [2:0] anaBits = {converterEnable, tempSensorEnable, supplyDividerEnable};
  wire [2:0] avgBits = {testMode, testPolarity};
  int badCount = 0, nCompared = 0;
  always #5 mclk = ~mclk;
  adcsc_top dut (.mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r), .sampleReq(sampleReq),
    .sampleDone(sampleDone), .sampleData(sampleData), .convClk(convClk),
    .converterEnable(converterEnable), .inputChannelSelect(inputChannelSelect),
    .channelReserved(channelReserved), .testMode(testMode), .testPolarity(testPolarity),
    .tempSensorEnable(tempSensorEnable), .supplyDividerEnable(supplyDividerEnable),
    .amplifierEnable(amplifierEnable), .fullscaleReferenceSelect(fullscaleReferenceSelect),
    .amplifierReferenceSelect(amplifierReferenceSelect),
    .amplifierInputGround(amplifierInputGround), .amplifierGain(amplifierGain),
    .convBusy(convBusy), .irq(irq));
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    #1;
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    `CHK(regRdata_r, e)
  endtask
  // Starts a conversion and answers each sample request; returns count and sum
  task conv(input logic [7:0] c, input logic [11:0] b, output int n, output int s);
    int i;
    logic go;
    logic [11:0] v;
    n = 0;
    s = 0;
    go = 1'b0;
    v = b;
    wr(8'hCE, c | 8'h01);
    for (i = 0; i < 4000; i++) begin
      @(posedge mclk);
      sampleDone <= go;
      sampleData <= go ? v : ~sampleData;
      #1;
      if (!go && sampleReq === 1'b1) begin
        go = 1'b1;
        v = b + 12'(n * 5);
        s += v;
        n++;
      end else go = 1'b0;
      if (convBusy !== 1'b1) break;
    end
    // A conversion that never ends counts as a mismatch here
    `CHK(convBusy, 1'b0)
  endtask
  task t_reset;
    rc(8'hCE, 8'h00);
    rc(8'hB9, 8'h00);
  endtask
  task t_div;
    int d;
    time t0;
    for (d = 0; d < 8; d++) begin
      wr(8'hA9, 8'h98 | 8'(d));
      @(posedge convClk);
      @(posedge convClk);
      t0 = $time;
      @(posedge convClk);
      `CHK(($time - t0) / 10, 2 << d)
    end
    `CHK(anaBits, 3'h7)
  endtask
  task t_regs;
    int c;
    wr(8'hB9, 8'hA6);
    `CHK(ampBits, 6'h2E)
    rc(8'hB9, 8'h00);
    wr(8'hB9, 8'h41);
    `CHK(ampBits, 6'h11)
    for (c = 0; c < 8; c++) begin
      wr(8'hCE, 8'(c << 2));
      `CHK(channelReserved, c > 5)
      `CHK(inputChannelSelect, 3'(c))
    end
  endtask
  task t_avg;
    int a, n, s, r;
    wr(8'hA9, 8'h80);
    // Bias settling of 20 us after the converter was switched on
    repeat (2000) @(posedge mclk);
    for (a = 0; a < 8; a++) begin
      conv(8'(a << 5), 12'h5A0 + 12'(a), n, s);
      r = a < 4 ? s >> a : s;
      `CHK(n, a < 4 ? 1 << a : 1)
      `CHK(avgBits, 3'(a))
      rc(8'hCE, 8'(a << 5) | 8'h02);
      rc(8'hBB, 8'(r >> 8));
      rc(8'hBA, 8'(r));
      rc(8'hCE, 8'(a << 5));
    end
    wr(8'hA9, 8'hA0);
    conv(8'h00, 12'h9C3, n, s);
    rc(8'hBB, 8'h9C);
    rc(8'hBA, 8'h30);
  endtask
  task t_irq;
    int n, s;
    wr(8'hA9, 8'hC0);
    wr(8'hC2, 8'h03);
    conv(8'h00, 12'h321, n, s);
    `CHK(irq, 1'b1)
    rc(8'hC0, 8'h01);
    conv(8'h00, 12'h654, n, s);
    rc(8'hC0, 8'h03);
    rc(8'hCE, 8'h02);
    rc(8'hBB, 8'h03);
    rc(8'hBA, 8'h21);
    wr(8'hC2, 8'h00);
    `CHK(irq, 1'b0)
    wr(8'hC2, 8'h03);
    `CHK(irq, 1'b1)
    wr(8'hC1, 8'h03);
    `CHK(irq, 1'b0)
    wr(8'hA9, 8'h80);
    conv(8'h00, 12'h777, n, s);
    `CHK(irq, 1'b0)
    rc(8'hC0, 8'h00);
    rc(8'hBA, 8'h77);
  endtask
  task completeRun;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    t_reset;
    t_div;
    t_regs;
    t_avg;
    t_irq;
    completeRun;
  end
  initial begin
    #500000;
    badCount++;
    completeRun;
  end
endmodule // adc_sequence_control_tb_top
`default_nettype wire
